// ==== verilog/ccp_top.sv ====
// capture/compare pwm output stage with axi4-lite registers
// Function
// R1 - asym mode: alternation bit gates each pair on alternately every counter cycle
// R2 - output-mode 00 disables compare, pin undriven; this is reset state
// R3 - basic mode: 01 high then low on match, 11 toggles; 10 invalid
// R4 - asym: 01 set match, clear underflow; sym: 01 clear up, set down; 11 inverts
// R5 - pin changes appear the cycle after the event
// R6 - compare byte writes land in shadow registers
// R7 - pwm mode: update bit arms shadow transfer at next overflow
// R8 - basic mode: update bit transfers at once and reads zero
// R9 - update bit reads one while transfer pending, zero afterwards
// R10 - compare reads return latest shadow value
// R11 - one update request moves all compares and the reload value
// R12 - halt enabled: capture a freezes pins at forced levels; capture continues
// R13 - timer keeps counting while halted
// R14 - halt sets status bit; outputs stay halted until software clears it
// R15 - writing one to halt status forces halt
// R16 - timer runs from multiplier output clock
// R17 - reference is peripheral clock divided by divider field plus one
// R18 - multiplier enable reads one only after lock
// R19 - software sets up with timer stopped, waits lock, then starts timer
// R20 - flags cross late when unit clock asynchronous; avoid timer access
// R21 - seven flags anded with enables drive one irq, fixed priority
// R22 - handler reads encoder, clears flag with zero, repeats until 000
// R23 - encoder: 000 none, 001-100 compare d..a, 101 cap b, 110 cap a, 111 ovf
// R24 - asym mode counts down, direction bit reads one
// R25 - output-mode 10 treated as disabled, pin undriven
`timescale 1ns/1ps
`default_nettype none
module ccp_top (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [9:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [9:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        cap_a_in,
	input  wire logic        cap_b_in,
	output var  logic [3:0]  cmp_out,
	output var  logic [3:0]  cmp_oe,
	output var  logic        irq
);
	// ==========================================================
	// state
	typedef struct packed {
		logic                         awr;
		logic                         wr;
		logic                         aw_h;
		logic [7:0]                   aw_i;
		logic                         w_h;
		logic [7:0]                   w_d;
		logic                         w_s;
		logic                         bv;
		logic [1:0]                   br;
		logic                         arr;
		logic                         rv;
		logic [7:0]                   rd;
		logic [1:0]                   rr;
		ccp_pkg::ccp_tmode_t          tmode;
		logic                         dir;
		logic                         hen;
		logic                         halt;
		logic                         alternate_pair_first;
		logic                         alternate_pair_second;
		logic                         multiplier_enable;
		logic [3:0]                   div;
		logic                         upd;
		logic [7:0]                   flg;
		logic [7:0]                   ien;
		logic [3:0][2:0]              ccfg;
		logic [4:0][15:0]             shd;
		logic [4:0][15:0]             act;
		logic [15:0]                  cnt;
		logic                         up;
		logic                         phase;
		logic [3:0]                   lev;
		logic [3:0]                   pin;
		logic [3:0]                   oe;
		logic [1:0]                   cap_q;
		logic                         irq;
	} ccp_state_t;

	ccp_state_t st_r;
	ccp_state_t st_nxt;
	logic       cap_a_lvl;
	logic       cap_b_lvl;
	logic       pll_locked;

	// ==========================================================
	// helpers
	function automatic logic idx_mapped(input logic [7:0] idx);
		idx_mapped = (idx == ccp_pkg::IDX_CTRL0) || (idx == ccp_pkg::IDX_CTRL1) ||
			(idx == ccp_pkg::IDX_IEN) || (idx == ccp_pkg::IDX_ENC) ||
			(idx == ccp_pkg::IDX_FLG) ||
			(idx >= ccp_pkg::IDX_CCFG && idx < ccp_pkg::IDX_CCFG + 8'h04) ||
			(idx >= ccp_pkg::IDX_CMP && idx < ccp_pkg::IDX_CMP + 8'h0A);
	endfunction : idx_mapped

	function automatic logic [2:0] prio_enc(input logic [7:0] p);
		if (p[ccp_pkg::F_OVF]) begin
			prio_enc = 3'h7;
		end else if (p[ccp_pkg::F_CAPA]) begin
			prio_enc = 3'h6;
		end else if (p[ccp_pkg::F_CAPB]) begin
			prio_enc = 3'h5;
		end else if (p[ccp_pkg::F_CMP0]) begin
			prio_enc = 3'h4;
		end else if (p[ccp_pkg::F_CMP0 + 1]) begin
			prio_enc = 3'h3;
		end else if (p[ccp_pkg::F_CMP0 + 2]) begin
			prio_enc = 3'h2;
		end else if (p[ccp_pkg::F_CMP0 + 3]) begin
			prio_enc = 3'h1;
		end else begin
			prio_enc = 3'h0;
		end
	endfunction : prio_enc

	function automatic logic ch_enabled(input logic [2:0] cfg);
		ch_enabled = cfg[ccp_pkg::CF_MLO];
	endfunction : ch_enabled

	// ==========================================================
	// input synchronisers and multiplier
	ccp_sync3 u_sync_a (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.din     (cap_a_in),
		.dout    (cap_a_lvl)
	);

	ccp_sync3 u_sync_b (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.din     (cap_b_in),
		.dout    (cap_b_lvl)
	);

	ccp_pll u_pll (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.enable  (st_r.multiplier_enable),
		.div     (st_r.div),
		.locked  (pll_locked)
	);

	// ==========================================================
	// next state
	always_comb begin
		logic        run;
		logic        pwm;
		logic        ovf;
		logic        unf;
		logic        cap_a_ev;
		logic        cap_b_ev;
		logic        wr_go;
		logic        upd_wr;
		logic        xfer;
		logic        inv;
		logic        gate;
		logic [7:0]  fset;
		logic [3:0]  match;
		logic [7:0]  ridx;
		logic [7:0]  wd;
		run      = 1'b0;
		pwm      = 1'b0;
		ovf      = 1'b0;
		unf      = 1'b0;
		cap_a_ev = 1'b0;
		cap_b_ev = 1'b0;
		wr_go    = 1'b0;
		upd_wr   = 1'b0;
		xfer     = 1'b0;
		inv      = 1'b0;
		gate     = 1'b1;
		fset     = 8'h00;
		match    = 4'h0;
		ridx     = 8'h00;
		wd       = st_r.w_d;
		st_nxt   = st_r;

		// timer events
		run = pll_locked && (st_r.tmode != ccp_pkg::TM_STOP); // [R16]
		pwm = (st_r.tmode == ccp_pkg::TM_ASYM) || (st_r.tmode == ccp_pkg::TM_SYM);
		cap_a_ev = cap_a_lvl && !st_r.cap_q[0];
		cap_b_ev = cap_b_lvl && !st_r.cap_q[1];
		st_nxt.cap_q = {cap_b_lvl, cap_a_lvl};
		if (run) begin // [R13]
			unique case (st_r.tmode)
				ccp_pkg::TM_BASIC: begin
					if (!st_r.dir) begin
						ovf = (st_r.cnt == st_r.act[ccp_pkg::RLD_SLOT]);
						st_nxt.cnt = ovf ? 16'h0000 : st_r.cnt + 16'h0001;
					end else begin
						ovf = (st_r.cnt == 16'h0000);
						st_nxt.cnt = ovf ? st_r.act[ccp_pkg::RLD_SLOT] : st_r.cnt - 16'h0001;
					end
				end
				ccp_pkg::TM_ASYM: begin
					unf = (st_r.cnt == 16'h0000); // [R24]
					ovf = unf;
					st_nxt.cnt = unf ? st_r.act[ccp_pkg::RLD_SLOT] : st_r.cnt - 16'h0001;
				end
				ccp_pkg::TM_SYM: begin
					if (st_r.up) begin
						if (st_r.cnt >= st_r.act[ccp_pkg::RLD_SLOT]) begin
							ovf = 1'b1;
							st_nxt.up = 1'b0;
							st_nxt.cnt = st_r.cnt - 16'h0001;
						end else begin
							st_nxt.cnt = st_r.cnt + 16'h0001;
						end
					end else if (st_r.cnt == 16'h0000) begin
						unf = 1'b1;
						st_nxt.up = 1'b1;
						st_nxt.cnt = 16'h0001;
					end else begin
						st_nxt.cnt = st_r.cnt - 16'h0001;
					end
				end
				ccp_pkg::TM_STOP: begin
				end
			endcase
			for (int i = 0; i < ccp_pkg::NUM_CH; i++) begin
				match[i] = (st_r.cnt == st_r.act[i]) && ch_enabled(st_r.ccfg[i]);
			end
		end
		if (st_r.tmode == ccp_pkg::TM_ASYM && unf) begin
			st_nxt.phase = !st_r.phase; // [R1]
		end

		// hardware flag events
		fset[ccp_pkg::F_OVF]  = ovf;
		fset[ccp_pkg::F_CAPA] = cap_a_ev;
		fset[ccp_pkg::F_CAPB] = cap_b_ev;
		for (int i = 0; i < ccp_pkg::NUM_CH; i++) begin
			fset[ccp_pkg::F_CMP0 + i] = match[i];
		end

		// ------------------------------------------------------
		// axi write channel
		if (s_axi_awvalid && st_r.awr) begin
			st_nxt.awr  = 1'b0;
			st_nxt.aw_h = 1'b1;
			st_nxt.aw_i = s_axi_awaddr[9:2];
		end
		if (s_axi_wvalid && st_r.wr) begin
			st_nxt.wr  = 1'b0;
			st_nxt.w_h = 1'b1;
			st_nxt.w_d = s_axi_wdata[7:0];
			st_nxt.w_s = s_axi_wstrb[0];
		end
		if (st_r.aw_h && st_r.w_h && !st_r.bv) begin
			wr_go       = st_r.w_s && idx_mapped(st_r.aw_i);
			st_nxt.aw_h = 1'b0;
			st_nxt.w_h  = 1'b0;
			st_nxt.bv   = 1'b1;
			st_nxt.br   = idx_mapped(st_r.aw_i) ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
		end
		if (st_r.bv && s_axi_bready) begin
			st_nxt.bv  = 1'b0;
			st_nxt.awr = 1'b1;
			st_nxt.wr  = 1'b1;
		end
		if (wr_go) begin
			unique case (st_r.aw_i)
				ccp_pkg::IDX_CTRL0: begin
					st_nxt.tmode = ccp_pkg::ccp_tmode_t'(wd[ccp_pkg::C0_MODE_HI:ccp_pkg::C0_MODE_LO]);
					if (st_r.tmode != ccp_pkg::TM_SYM) begin
						st_nxt.dir = wd[ccp_pkg::C0_DIR];
					end
					st_nxt.hen   = wd[ccp_pkg::C0_HEN];
					st_nxt.halt  = wd[ccp_pkg::C0_HALT]; // [R14] [R15]
					st_nxt.alternate_pair_first = wd[ccp_pkg::C0_ALTERNATE_PAIR_FIRST];
					st_nxt.alternate_pair_second = wd[ccp_pkg::C0_ALTERNATE_PAIR_SECOND];
					st_nxt.multiplier_enable = wd[ccp_pkg::C0_MULTIPLIER_ENABLE];
				end
				ccp_pkg::IDX_CTRL1: begin
					st_nxt.div = wd[ccp_pkg::C1_DIV_HI:0]; // [R17]
					upd_wr     = wd[ccp_pkg::C1_UPD];
				end
				ccp_pkg::IDX_IEN: begin
					st_nxt.ien = wd & ccp_pkg::FLG_MASK;
				end
				ccp_pkg::IDX_FLG: begin
					st_nxt.flg = st_r.flg & wd & ccp_pkg::FLG_MASK; // [R22]
				end
				default: begin
					for (int i = 0; i < ccp_pkg::NUM_CH; i++) begin
						if (st_r.aw_i == 8'(ccp_pkg::IDX_CCFG + i)) begin
							st_nxt.ccfg[i] = wd[ccp_pkg::CF_FCO:0];
						end
					end
					for (int k = 0; k < ccp_pkg::NUM_CMP; k++) begin
						if (st_r.aw_i == 8'(ccp_pkg::IDX_CMP + 2 * k)) begin
							st_nxt.shd[k][7:0] = wd; // [R6]
						end
						if (st_r.aw_i == 8'(ccp_pkg::IDX_CMP + 2 * k + 1)) begin
							st_nxt.shd[k][15:8] = wd; // [R6]
						end
					end
				end
			endcase
		end

		// ------------------------------------------------------
		// shadow transfer, all slots together
		if (upd_wr && pwm) begin
			st_nxt.upd = 1'b1; // [R7] [R9]
		end
		xfer = (upd_wr && !pwm) || (st_r.upd && ovf && pwm); // [R8] [R7]
		if (xfer) begin
			st_nxt.act = st_nxt.shd; // [R11]
			if (!(upd_wr && pwm)) begin
				st_nxt.upd = 1'b0; // [R9]
			end
		end
		if (!pwm && !(st_r.upd && ovf)) begin
			st_nxt.upd = st_nxt.upd && pwm;
		end

		// flags: hardware set beats software clear
		st_nxt.flg  = st_nxt.flg | fset;
		st_nxt.halt = st_nxt.halt | (st_r.hen && cap_a_ev); // [R12] [R14]

		// ------------------------------------------------------
		// compare pins, registered so changes land next cycle
		for (int i = 0; i < ccp_pkg::NUM_CH; i++) begin
			inv = st_r.ccfg[i][ccp_pkg::CF_MHI];
			if (!ch_enabled(st_r.ccfg[i])) begin
				st_nxt.oe[i] = 1'b0; // [R2] [R25]
			end else begin
				st_nxt.oe[i] = 1'b1;
				unique case (st_r.tmode)
					ccp_pkg::TM_BASIC: begin
						if (!inv && !st_r.oe[i]) begin
							st_nxt.lev[i] = 1'b1; // [R3]
						end else if (match[i]) begin
							st_nxt.lev[i] = inv ? !st_r.lev[i] : 1'b0; // [R3]
						end
					end
					ccp_pkg::TM_ASYM: begin
						if (match[i]) begin
							st_nxt.lev[i] = !inv; // [R4]
						end else if (unf) begin
							st_nxt.lev[i] = inv; // [R4]
						end
					end
					ccp_pkg::TM_SYM: begin
						if (match[i]) begin
							st_nxt.lev[i] = st_r.up ? inv : !inv; // [R4]
						end
					end
					ccp_pkg::TM_STOP: begin
					end
				endcase
			end
			gate = 1'b1;
			if (st_r.tmode == ccp_pkg::TM_ASYM && ((i < 2) ? st_r.alternate_pair_first : st_r.alternate_pair_second)) begin
				gate = (i % 2 == 0) ? !st_nxt.phase : st_nxt.phase; // [R1]
			end
			if (st_nxt.halt) begin
				st_nxt.pin[i] = st_r.ccfg[i][ccp_pkg::CF_FCO]; // [R12]
			end else begin
				st_nxt.pin[i] = st_nxt.lev[i] && gate; // [R5]
			end
		end

		// ------------------------------------------------------
		// axi read channel
		if (s_axi_arvalid && st_r.arr) begin
			ridx       = s_axi_araddr[9:2];
			st_nxt.arr = 1'b0;
			st_nxt.rv  = 1'b1;
			st_nxt.rd  = 8'h00;
			st_nxt.rr  = idx_mapped(ridx) ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
			unique case (ridx)
				ccp_pkg::IDX_CTRL0: begin
					st_nxt.rd[ccp_pkg::C0_MODE_HI:ccp_pkg::C0_MODE_LO] = st_r.tmode;
					st_nxt.rd[ccp_pkg::C0_DIR] = (st_r.tmode == ccp_pkg::TM_ASYM) ? 1'b1 : // [R24]
						(st_r.tmode == ccp_pkg::TM_SYM) ? !st_r.up : st_r.dir;
					st_nxt.rd[ccp_pkg::C0_HEN]   = st_r.hen;
					st_nxt.rd[ccp_pkg::C0_HALT]  = st_r.halt;
					st_nxt.rd[ccp_pkg::C0_ALTERNATE_PAIR_FIRST] = st_r.alternate_pair_first;
					st_nxt.rd[ccp_pkg::C0_ALTERNATE_PAIR_SECOND] = st_r.alternate_pair_second;
					st_nxt.rd[ccp_pkg::C0_MULTIPLIER_ENABLE] = st_r.multiplier_enable && pll_locked; // [R18]
				end
				ccp_pkg::IDX_CTRL1: begin
					st_nxt.rd[ccp_pkg::C1_DIV_HI:0] = st_r.div;
					st_nxt.rd[ccp_pkg::C1_UPD]      = st_r.upd; // [R8] [R9]
				end
				ccp_pkg::IDX_IEN: begin
					st_nxt.rd = st_r.ien;
				end
				ccp_pkg::IDX_FLG: begin
					st_nxt.rd = st_r.flg;
				end
				ccp_pkg::IDX_ENC: begin
					st_nxt.rd = {5'h00, prio_enc(st_r.flg & st_r.ien)}; // [R21] [R23]
				end
				default: begin
					for (int i = 0; i < ccp_pkg::NUM_CH; i++) begin
						if (ridx == 8'(ccp_pkg::IDX_CCFG + i)) begin
							st_nxt.rd = {5'h00, st_r.ccfg[i]}; // [R12]
						end
					end
					for (int k = 0; k < ccp_pkg::NUM_CMP; k++) begin
						if (ridx == 8'(ccp_pkg::IDX_CMP + 2 * k)) begin
							st_nxt.rd = st_r.shd[k][7:0]; // [R10]
						end
						if (ridx == 8'(ccp_pkg::IDX_CMP + 2 * k + 1)) begin
							st_nxt.rd = st_r.shd[k][15:8]; // [R10]
						end
					end
				end
			endcase
		end
		if (st_r.rv && s_axi_rready) begin
			st_nxt.rv  = 1'b0;
			st_nxt.arr = 1'b1;
		end

		// shared interrupt line
		st_nxt.irq = |(st_r.flg & st_r.ien & ccp_pkg::FLG_MASK); // [R20] [R21]
	end

	// ==========================================================
	// registers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r     <= '0;
			st_r.awr <= 1'b1;
			st_r.wr  <= 1'b1;
			st_r.arr <= 1'b1;
			st_r.up  <= 1'b1;
			st_r.shd <= {ccp_pkg::NUM_CMP{ccp_pkg::RST_CMP}};
			st_r.act <= {ccp_pkg::NUM_CMP{ccp_pkg::RST_CMP}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready = st_r.awr;
	assign s_axi_wready  = st_r.wr;
	assign s_axi_bvalid  = st_r.bv;
	assign s_axi_bresp   = st_r.br;
	assign s_axi_arready = st_r.arr;
	assign s_axi_rvalid  = st_r.rv;
	assign s_axi_rdata   = {24'h000000, st_r.rd};
	assign s_axi_rresp   = st_r.rr;
	assign cmp_out       = st_r.pin;
	assign cmp_oe        = st_r.oe;
	assign irq           = st_r.irq;
endmodule : ccp_top
`default_nettype wire

// ==== include/ccp_pkg.sv ====
// constants shared by the capture/compare pwm output stage
`default_nettype none
package ccp_pkg;
	// ==========================================================
	// register indices (byte address = 4 * index)
	localparam logic [7:0] IDX_CTRL0 = 8'hC8;
	localparam logic [7:0] IDX_IEN   = 8'hC9;
	localparam logic [7:0] IDX_ENC   = 8'hDE;
	localparam logic [7:0] IDX_FLG   = 8'hE9;
	localparam logic [7:0] IDX_CTRL1 = 8'hF9;
	localparam logic [7:0] IDX_CCFG  = 8'hD0;
	localparam logic [7:0] IDX_CMP   = 8'hA0;
	localparam int         NUM_CH    = 4;
	localparam int         NUM_CMP   = 5;
	localparam int         RLD_SLOT  = 4;
	localparam int         ADDR_W    = 10;
	// ==========================================================
	// control zero fields
	localparam int C0_MODE_LO = 0;
	localparam int C0_MODE_HI = 1;
	localparam int C0_DIR     = 2;
	localparam int C0_HEN     = 3;
	localparam int C0_HALT    = 4;
	localparam int C0_ALTERNATE_PAIR_FIRST   = 5;
	localparam int C0_ALTERNATE_PAIR_SECOND   = 6;
	localparam int C0_MULTIPLIER_ENABLE   = 7;
	// control one fields
	localparam int C1_DIV_HI  = 3;
	localparam int C1_UPD     = 7;
	// channel config fields
	localparam int CF_MLO     = 0;
	localparam int CF_MHI     = 1;
	localparam int CF_FCO     = 2;
	// ==========================================================
	// flag / enable bit positions
	localparam int F_CAPA     = 0;
	localparam int F_CAPB     = 1;
	localparam int F_CMP0     = 3;
	localparam int F_OVF      = 7;
	localparam logic [7:0] FLG_MASK = 8'hFB;
	// ==========================================================
	// reset values and timing
	localparam logic [15:0] RST_CMP       = 16'h0000;
	localparam logic [7:0]  PLL_LOCK_REFS = 8'h40;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// ==========================================================
	// timer modes
	typedef enum logic [1:0] {
		TM_STOP,
		TM_BASIC,
		TM_ASYM,
		TM_SYM
	} ccp_tmode_t;
endpackage : ccp_pkg
`default_nettype wire

// ==== verilog/ccp_sync3.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ccp_sync3 (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic din,
	output var  logic dout
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} ccp_sync_t;

	ccp_sync_t st_r;
	ccp_sync_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// change accepted once stages two and three agree
		if (st_r.s2 == st_r.s3) begin
			st_nxt.lvl = st_r.s3;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.lvl;
endmodule : ccp_sync3
`default_nettype wire

// ==== verilog/ccp_pll.sv ====
// reference prescaler and lock model of the clock multiplier
`timescale 1ns/1ps
`default_nettype none
module ccp_pll (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       enable,
	input  wire logic [3:0] div,
	output var  logic       locked
);
	typedef struct packed {
		logic [3:0] pre;
		logic [7:0] refs;
		logic       lock;
	} ccp_pll_t;

	ccp_pll_t st_r;
	ccp_pll_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (!enable) begin
			st_nxt = '0;
		end else if (st_r.pre >= div) begin
			// one reference period of div+1 cycles
			st_nxt.pre = 4'h0; // [R17]
			if (st_r.refs >= ccp_pkg::PLL_LOCK_REFS) begin
				st_nxt.lock = 1'b1; // [R18]
			end else begin
				st_nxt.refs = st_r.refs + 8'h01;
			end
		end else begin
			st_nxt.pre = st_r.pre + 4'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign locked = st_r.lock;
endmodule : ccp_pll
`default_nettype wire

// ==== bench/ccp_properties.sv ====
// bus handshake and pin checks for the pwm output stage
`timescale 1ns/1ps
`default_nettype none
module ccp_properties (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [3:0]  cmp_oe,
	input wire logic        irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// assertions
	a_reset_pins_off: assert property ($rose(rst_n) |-> cmp_oe == 4'h0 && !irq)
		else $error("pins driven after reset");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	a_write_released: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write answer not released");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_read_released: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read answer not released");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == ccp_pkg::RESP_SLVERR);
	c_irq_up: cover property ($rose(irq));
	c_irq_down: cover property ($fell(irq));
endmodule : ccp_properties
`default_nettype wire

// ==== bench/ccp_bridge_model.sv ====
// bridge driver stage: fires capture pins, times pin on-phases
`timescale 1ns/1ps
`default_nettype none
module ccp_bridge_model (
	input wire logic       sys_clk,
	input wire logic [3:0] cmp_out,
	input wire logic [3:0] cmp_oe,
	output var logic       cap_a_in,
	output var logic       cap_b_in
);
	initial begin
		cap_a_in = 1'b0;
		cap_b_in = 1'b0;
	end
	// pulse long enough to pass the agreement filter
	task automatic pulse(input int which);
		@(posedge sys_clk);
		if (which == 0) cap_a_in <= 1'b1;
		else cap_b_in <= 1'b1;
		repeat (6) @(posedge sys_clk);
		cap_a_in <= 1'b0;
		cap_b_in <= 1'b0;
	endtask : pulse
	task automatic on_time(input int b, input int n, output int hi);
		hi = 0;
		repeat (n) begin
			@(negedge sys_clk);
			if (cmp_oe[b] === 1'b1 && cmp_out[b] === 1'b1) hi++;
		end
	endtask : on_time
endmodule : ccp_bridge_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0] C0 = ccp_pkg::IDX_CTRL0;
	localparam logic [7:0] C1 = ccp_pkg::IDX_CTRL1;
	localparam logic [7:0] IE = ccp_pkg::IDX_IEN;
	localparam logic [7:0] EN = ccp_pkg::IDX_ENC;
	localparam logic [7:0] FG = ccp_pkg::IDX_FLG;
	localparam logic [7:0] CM = ccp_pkg::IDX_CMP;
	localparam logic [7:0] CF = ccp_pkg::IDX_CCFG;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [9:0]  awaddr = 10'h000;
	logic [9:0]  araddr = 10'h000;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq, cap_a, cap_b;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [3:0]  cmp_out, cmp_oe;
	int          err_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;
	ccp_top dut (.sys_clk, .rst_n, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .cap_a_in(cap_a), .cap_b_in(cap_b), .cmp_out, .cmp_oe, .irq);
	ccp_bridge_model bridge (.sys_clk, .cmp_out, .cmp_oe, .cap_a_in(cap_a), .cap_b_in(cap_b));
	// ==========================================================
	// bus master and compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic a, w;
		@(posedge sys_clk);
		awaddr <= {i, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge sys_clk);
			a = awvalid && awready;
			w = wvalid && wready;
			@(posedge sys_clk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		do @(negedge sys_clk); while (bvalid !== 1'b1);
		chk(bresp, er, "bresp");
		@(posedge sys_clk);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] i, output logic [7:0] d, input logic [1:0] er = 2'h0);
		@(posedge sys_clk);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge sys_clk); while (arready !== 1'b1);
		@(posedge sys_clk);
		arvalid <= 1'b0;
		do @(negedge sys_clk); while (rvalid !== 1'b1);
		d = rdata[7:0];
		chk(rresp, er, "rresp");
		@(posedge sys_clk);
		rready <= 1'b0;
	endtask : rd
	task automatic rdchk(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
		logic [7:0] v;
		rd(i, v, er);
		chk(v, e, $sformatf("reg %h", i));
	endtask : rdchk
	task automatic wait_irq();
		repeat (2) @(negedge sys_clk);
		while (irq !== 1'b1) @(negedge sys_clk);
	endtask : wait_irq
	// ==========================================================
	// scenarios
	task automatic t_reset();
		chk(cmp_oe, 4'h0, "oe at reset");
		rdchk(C1, 8'h00);
		rdchk(EN, 8'h00);
		rdchk(8'h7F, 8'h00, ccp_pkg::RESP_SLVERR);
		wr(8'h7F, 8'h01, ccp_pkg::RESP_SLVERR);
		$display("done reset");
	endtask : t_reset
	task automatic t_pll();
		logic [7:0] v;
		int         t0;
		wr(C1, 8'h01);
		wr(C0, 8'h80);
		t0 = cyc;
		rdchk(C0, 8'h00);
		do rd(C0, v); while (v[7] !== 1'b1);
		chk((cyc - t0) inside {[int'(ccp_pkg::PLL_LOCK_REFS) * 2 - 4 : int'(ccp_pkg::PLL_LOCK_REFS) * 2 + 12]},
			1, "lock time");
		$display("done pll");
	endtask : t_pll
	task automatic t_shadow();
		wr(CM + 8'h09, 8'h01);
		wr(CM + 8'h08, 8'h00);
		wr(C1, 8'h81);
		wr(C0, 8'h81);
		wr(CM, 8'h33);
		wr(C1, 8'h81);
		rdchk(C1, 8'h01);
		rdchk(CM, 8'h33);
		wr(CF, 8'h01);
		wr(C0, 8'h82);
		rdchk(C0, 8'h86);
		wr(IE, 8'h80);
		wait_irq();
		rdchk(EN, 8'h07);
		wr(IE, 8'h00);
		rdchk(EN, 8'h00);
		chk(irq, 1'b0, "masked irq");
		wr(IE, 8'h80);
		wr(FG, 8'h00);
		wait_irq();
		wr(CM, 8'h55);
		wr(C1, 8'h81);
		rdchk(C1, 8'h81);
		rdchk(CM, 8'h55);
		wr(FG, 8'h00);
		wait_irq();
		rdchk(C1, 8'h01);
		$display("done shadow");
	endtask : t_shadow
	task automatic t_pwm();
		int hi;
		bridge.on_time(0, 514, hi);
		chk(hi inside {[170:175]}, 1, "asym duty");
		wr(C0, 8'hA2);
		bridge.on_time(0, 514, hi);
		chk(hi inside {[84:89]}, 1, "alternate duty");
		$display("done pwm");
	endtask : t_pwm
	task automatic t_halt();
		logic [7:0] v;
		int         hi;
		wr(C0, 8'h8A);
		wr(CF, 8'h05);
		wr(CF + 8'h01, 8'h01);
		wr(IE, 8'h03);
		bridge.pulse(1);
		bridge.pulse(0);
		repeat (4) @(negedge sys_clk);
		chk(cmp_out[1:0], 2'b01, "halt levels");
		wr(FG, 8'h7F);
		bridge.on_time(0, 300, hi);
		chk(hi, 300, "held during halt");
		rd(FG, v);
		chk(v & 8'h83, 8'h83, "flags in halt");
		rdchk(EN, 8'h06);
		rdchk(CF, 8'h05);
		rdchk(C0, 8'h9E);
		wr(C0, 8'h8A);
		rdchk(C0, 8'h8E);
		wr(C0, 8'h9A);
		rdchk(C0, 8'h9E);
		chk(cmp_out[1:0], 2'b01, "forced halt");
		$display("done halt");
	endtask : t_halt
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_pll();
		t_shadow();
		t_pwm();
		t_halt();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		$display("BAD t=%0t watchdog", $time);
		tally_and_finish();
	end
endmodule : tb_top
bind ccp_top ccp_properties u_props (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_oe, .irq);
`default_nettype wire
